//--- logic/clamp_chan.sv
// One channel: source switch selection, decimation filter, clamp comparator.
// Assumes converter samples arrive synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module clamp_chan
    import vclamp_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire chan_cfg_t cfg,
    input wire logic [SAMPLE_W-1:0] adc_in,
    input wire logic clamp_en,
    input wire logic line_end,
    output logic [SRC_W-1:0] src_sel,
    output logic [SAMPLE_W-1:0] filt_out,
    output clamp_cmd_t clamp_cmd
);
    logic [SAMPLE_W-1:0] prev_q, prev_d, filt_q, filt_d;
    logic [SAMPLE_W-1:0] target;
    logic seen_q, seen_d, hi_q, hi_d, lo_q, lo_d;
    clamp_cmd_t cmd_q, cmd_d;
    logic [SAMPLE_W:0] sum;

    always_comb begin
        unique case (cfg.kind)
            IN_LUMA: target = CLAMP_LUMA;
            IN_CHROMA: target = CLAMP_CHROMA;
            IN_COMP_Y: target = CLAMP_COMP_Y;
            IN_COMP_C: target = CLAMP_COMP_C;
            IN_RGB: target = CLAMP_RGB;
            default: target = CLAMP_LUMA;
        endcase
    end

    always_comb begin
        sum = {1'b0, adc_in} + {1'b0, prev_q};
        prev_d = adc_in;
        filt_d = sum[SAMPLE_W:1];
        seen_d = seen_q;
        hi_d = hi_q;
        lo_d = lo_q;
        cmd_d = cmd_q;
        if (line_end) begin
            cmd_d.up = seen_q && lo_q;
            cmd_d.down = seen_q && hi_q;
            seen_d = 1'b0;
        end
        // Window opening on the line end cycle belongs to the next line
        if (clamp_en && (!seen_q || line_end)) begin
            seen_d = 1'b1;
            hi_d = filt_q > target;
            lo_d = filt_q < target;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            prev_q <= '0;
            filt_q <= '0;
            seen_q <= 1'b0;
            hi_q <= 1'b0;
            lo_q <= 1'b0;
            cmd_q <= '0;
        end else begin
            prev_q <= prev_d;
            filt_q <= filt_d;
            seen_q <= seen_d;
            hi_q <= hi_d;
            lo_q <= lo_d;
            cmd_q <= cmd_d;
        end
    end

    assign src_sel = cfg.source;
    assign filt_out = filt_q;
    assign clamp_cmd = cmd_q;

    property p_one_dir;
        @(posedge clk) disable iff (!nrst) !(clamp_cmd.up && clamp_cmd.down);
    endproperty
    a_one_dir: assert property (p_one_dir) else $error("clamp up and down together");
    property p_cmd_line;
        @(posedge clk) disable iff (!nrst) !$past(line_end) |-> $stable(clamp_cmd);
    endproperty
    a_cmd_line: assert property (p_cmd_line) else $error("clamp changed mid line");
endmodule
`default_nettype wire

//--- logic/vclamp_pkg.sv
// Constants and carrier types for the video clamp and gain control block.
// Assumes a single 100 MHz line-locked clock domain.
package vclamp_pkg;
    localparam int NUM_CH = 4;
    localparam int SAMPLE_W = 9;
    localparam int GAIN_W = 9;
    localparam int SRC_W = 2;
    localparam logic [SAMPLE_W-1:0] CLAMP_LUMA = 9'h078;
    localparam logic [SAMPLE_W-1:0] CLAMP_CHROMA = 9'h100;
    localparam logic [SAMPLE_W-1:0] CLAMP_COMP_Y = 9'h020;
    localparam logic [SAMPLE_W-1:0] CLAMP_COMP_C = 9'h100;
    localparam logic [SAMPLE_W-1:0] CLAMP_RGB = 9'h020;
    localparam logic [SAMPLE_W-1:0] SYNC_TARGET = 9'h010;
    localparam logic [SAMPLE_W-1:0] WHITE_PEAK = 9'h1F0;
    localparam logic [GAIN_W-1:0] GAIN_RESET = 9'h100;
    localparam logic [GAIN_W-1:0] GAIN_MAX = 9'h1FF;
    localparam logic [GAIN_W-1:0] GAIN_MIN = 9'h000;
    localparam logic [GAIN_W-1:0] PEAK_STEP = 9'h004;
    localparam int CLK_HZ = 100_000_000;
    localparam logic [7:0] FILT_DIV = 8'h40;
    typedef enum logic [2:0] {
        IN_LUMA, IN_CHROMA, IN_COMP_Y, IN_COMP_C, IN_RGB
    } input_type_t;
    typedef struct packed {
        input_type_t kind;
        logic [SRC_W-1:0] source;
    } chan_cfg_t;
    typedef struct packed {
        logic up;
        logic down;
    } clamp_cmd_t;
endpackage

//--- logic/video_clamp_gain_control.sv
// Top of the analog front-end control: four channels, clamp and gain loops.
// Assumes sync and blanking strobes come from pins of another domain.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Four channels: source switch, converter, decimation
// - Filter tune tracks line-locked clock
// - Vertical blanking freezes clamp and gain
// - Comparator gives clamp up or down
// - Fixed clamp targets per input type
// - Clamp evaluated only in gate pulse
// - Static gains or one automatic amplifier
// - Automatic gain fits converter range
// - Component inputs use manual fixed gain
// - Automatic gain samples its level only at sync bottom; the peak limiter watches every unblanked sample
// - White peak limiter cuts gain
module video_clamp_gain_control
    import vclamp_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire chan_cfg_t [NUM_CH-1:0] chan_cfg,
    input wire logic [NUM_CH-1:0][SAMPLE_W-1:0] adc_in,
    input wire logic clamp_gate_pulse,
    input wire logic sync_bottom,
    input wire logic vblank,
    input wire logic line_start,
    input wire logic [NUM_CH-1:0][GAIN_W-1:0] static_gain,
    input wire logic agc_enable,
    input wire logic [1:0] agc_channel,
    output logic [NUM_CH-1:0][SRC_W-1:0] src_sel,
    output logic [NUM_CH-1:0][SAMPLE_W-1:0] decimation_filter,
    output clamp_cmd_t [NUM_CH-1:0] clamp_cmd,
    output logic [NUM_CH-1:0][GAIN_W-1:0] gain_out,
    output logic filter_tune
);
    logic [3:0] s1_q, s2_q, s3_q;
    logic gate, sbot, vb, lend;
    logic [7:0] div_q, div_d;
    logic tune_q, tune_d;
    logic [GAIN_W-1:0] agc_q, agc_d;
    logic [NUM_CH-1:0][GAIN_W-1:0] gain_q, gain_d;
    logic seen_q, seen_d, low_q, low_d, peak_q, peak_d;
    logic agc_ok;
    logic [SAMPLE_W-1:0] agc_smp;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else begin
            s1_q <= {line_start, vblank, sync_bottom, clamp_gate_pulse};
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end
    assign vb = s2_q[2];
    assign gate = s2_q[0] && !vb;
    assign sbot = s2_q[1] && !vb;
    assign lend = s2_q[3] && !s3_q[3];

    genvar i;
    generate
        for (i = 0; i < NUM_CH; i++) begin : g_ch
            clamp_chan u_ch (
                .clk(clk),
                .nrst(nrst),
                .cfg(chan_cfg[i]),
                .adc_in(adc_in[i]),
                .clamp_en(gate),
                .line_end(lend && !vb),
                .src_sel(src_sel[i]),
                .filt_out(decimation_filter[i]),
                .clamp_cmd(clamp_cmd[i])
            );
        end
    endgenerate

    // Filter tune clock divided from the line-locked clock
    always_comb begin
        div_d = div_q + 8'h01;
        tune_d = tune_q;
        if (div_q == FILT_DIV - 8'h01) begin
            div_d = '0;
            tune_d = !tune_q;
        end
    end

    assign agc_smp = decimation_filter[agc_channel];
    assign agc_ok = agc_enable && (chan_cfg[agc_channel].kind inside {IN_LUMA});

    always_comb begin
        agc_d = agc_q;
        seen_d = seen_q;
        low_d = low_q;
        peak_d = peak_q;
        if (lend && !vb) begin
            if (peak_q) begin
                agc_d = (agc_q > PEAK_STEP) ? agc_q - PEAK_STEP : GAIN_MIN;
            end else if (seen_q && low_q && agc_q != GAIN_MAX) begin
                agc_d = agc_q + 9'h001;
            end else if (seen_q && !low_q && agc_q != GAIN_MIN) begin
                agc_d = agc_q - 9'h001;
            end
            seen_d = 1'b0;
            peak_d = 1'b0;
        end
        // Sample and peak events win over the line end clear
        if (sbot && (!seen_q || lend)) begin
            seen_d = 1'b1;
            low_d = agc_smp > SYNC_TARGET;
        end
        if (!vb && agc_smp >= WHITE_PEAK) begin
            peak_d = 1'b1;
        end
        for (int k = 0; k < NUM_CH; k++) begin
            gain_d[k] = (agc_ok && agc_channel == k[1:0]) ? agc_q : static_gain[k];
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            div_q <= '0;
            tune_q <= 1'b0;
            agc_q <= GAIN_RESET;
            seen_q <= 1'b0;
            low_q <= 1'b0;
            peak_q <= 1'b0;
            gain_q <= '0;
        end else begin
            div_q <= div_d;
            tune_q <= tune_d;
            agc_q <= agc_d;
            seen_q <= seen_d;
            low_q <= low_d;
            peak_q <= peak_d;
            gain_q <= gain_d;
        end
    end

    assign gain_out = gain_q;
    assign filter_tune = tune_q;

    sequence s_blank;
        vb;
    endsequence
    property p_freeze;
        @(posedge clk) disable iff (!nrst) s_blank ##1 vb |-> $stable(agc_q);
    endproperty
    a_freeze: assert property (p_freeze) else $error("gain moved in blanking");
    property p_step;
        @(posedge clk) disable iff (!nrst) !$past(lend) |-> $stable(agc_q);
    endproperty
    a_step: assert property (p_step) else $error("gain moved mid line");
    property p_peak;
        @(posedge clk) disable iff (!nrst) lend && !vb && peak_q && agc_q > PEAK_STEP
            |=> agc_q == $past(agc_q) - PEAK_STEP;
    endproperty
    a_peak: assert property (p_peak) else $error("peak did not cut gain");
    property p_static;
        @(posedge clk) disable iff (!nrst) !agc_ok |=> gain_out[0] == $past(static_gain[0]);
    endproperty
    a_static: assert property (p_static) else $error("static gain not applied");
    property p_tune;
        @(posedge clk) disable iff (!nrst) $changed(filter_tune) |-> ##64 $changed(filter_tune);
    endproperty
    a_tune: assert property (p_tune) else $error("tune period wrong");
    property p_grow;
        @(posedge clk) disable iff (!nrst) lend && !vb && !peak_q && seen_q && low_q
            && agc_q != GAIN_MAX |=> agc_q == $past(agc_q) + 9'h001;
    endproperty
    a_grow: assert property (p_grow) else $error("gain did not rise");
endmodule
`default_nettype wire

//--- tb/fe_model.sv
// Analog front-end stand-in: converter samples per channel.
// Assumes the bench sets each channel's analog level.
`timescale 1ns/1ps
`default_nettype none
module fe_model
    import vclamp_pkg::*;
(
    input wire logic clk,
    input wire logic [NUM_CH-1:0][SAMPLE_W-1:0] level,
    output logic [NUM_CH-1:0][SAMPLE_W-1:0] adc_in
);
    always_ff @(posedge clk) begin
        adc_in <= level;
    end
endmodule
`default_nettype wire

//--- tb/tb_top.sv
// Bench for the clamp and gain control block.
// Assumes one 100 MHz clock and the front-end model.
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import vclamp_pkg::*;
;
    logic clk = 1'b0;
    logic nrst, gate, sb, vb, ls, agc_en;
    logic [1:0] agc_ch;
    chan_cfg_t [3:0] cfg;
    logic [3:0][8:0] lvl, adc, sg, filt, gain;
    logic [3:0][1:0] src;
    clamp_cmd_t [3:0] cc;
    logic tune;
    int n_mismatch = 0;
    int samples_checked = 0;
    always #5 clk = ~clk;
    video_clamp_gain_control i_video_clamp_gain_control (.clk(clk), .nrst(nrst),
        .chan_cfg(cfg), .adc_in(adc), .clamp_gate_pulse(gate), .sync_bottom(sb),
        .vblank(vb), .line_start(ls), .static_gain(sg), .agc_enable(agc_en),
        .agc_channel(agc_ch), .src_sel(src), .decimation_filter(filt),
        .clamp_cmd(cc), .gain_out(gain), .filter_tune(tune));
    fe_model i_fe_model (.clk(clk), .level(lvl), .adc_in(adc));
    task automatic stop_test;
        $display("Comparisons %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    // One video line: windows, then line start, then settle
    task automatic line(input logic g, input logic s);
        tick(1);
        gate <= g;
        sb <= s;
        tick(4);
        gate <= 1'b0;
        sb <= 1'b0;
        ls <= 1'b1;
        tick(2);
        ls <= 1'b0;
        tick(8);
        #1;
    endtask
    task automatic set_all(input input_type_t k, input logic [8:0] v);
        tick(1);
        for (int i = 0; i < 4; i++) begin
            cfg[i] <= '{k, 2'(i)};
            lvl[i] <= v;
        end
    endtask
    task automatic set_vb(input logic v);
        tick(1);
        vb <= v;
        tick(3);
    endtask
    task automatic t_clamp;
        input_type_t kd[5] = '{IN_LUMA, IN_CHROMA, IN_COMP_Y, IN_COMP_C, IN_RGB};
        logic [8:0] tg[5] = '{CLAMP_LUMA, CLAMP_CHROMA, CLAMP_COMP_Y, CLAMP_COMP_C, CLAMP_RGB};
        int c;
        for (int k = 0; k < 5; k++) begin
            c = k % 4;
            set_all(kd[k], tg[k] - 9'h001);
            line(1'b1, 1'b0);
            chk(9'(cc[c]), 9'h002);
            chk(9'(src[c]), 9'(c));
            chk(filt[c], tg[k] - 9'h001);
            set_all(kd[k], tg[k] + 9'h001);
            line(1'b1, 1'b0);
            chk(9'(cc[c]), 9'h001);
            set_all(kd[k], tg[k]);
            line(1'b1, 1'b0);
            chk(9'(cc[c]), 9'h000);
        end
    endtask
    task automatic t_freeze;
        set_all(IN_LUMA, 9'h070);
        line(1'b0, 1'b0);
        chk(9'(cc[0]), 9'h000);
        line(1'b1, 1'b0);
        chk(9'(cc[0]), 9'h002);
        set_vb(1'b1);
        set_all(IN_LUMA, 9'h090);
        line(1'b1, 1'b0);
        chk(9'(cc[0]), 9'h002);
        set_vb(1'b0);
    endtask
    task automatic t_agc;
        set_all(IN_LUMA, 9'h040);
        tick(1);
        agc_en <= 1'b1;
        agc_ch <= 2'h1;
        line(1'b0, 1'b1);
        chk(gain[1], 9'h101);
        chk(gain[2], sg[2]);
        line(1'b0, 1'b1);
        chk(gain[1], 9'h102);
        line(1'b0, 1'b0);
        chk(gain[1], 9'h102);
        set_all(IN_LUMA, 9'h008);
        line(1'b0, 1'b1);
        chk(gain[1], 9'h101);
        set_all(IN_LUMA, WHITE_PEAK);
        line(1'b0, 1'b1);
        chk(gain[1], 9'h101 - PEAK_STEP);
        set_all(IN_LUMA, 9'h040);
        set_vb(1'b1);
        line(1'b0, 1'b1);
        chk(gain[1], 9'h101 - PEAK_STEP);
        set_vb(1'b0);
        set_all(IN_COMP_Y, 9'h040);
        line(1'b0, 1'b1);
        chk(gain[1], sg[1]);
    endtask
    task automatic t_tune;
        logic f;
        tick(1);
        #1 f = tune;
        tick(64);
        #1;
        chk(9'(tune != f), 9'h001);
    endtask
    initial begin
        #50us;
        n_mismatch++;
        stop_test();
    end
    initial begin
        {nrst, gate, sb, vb, ls, agc_en, agc_ch} = '0;
        for (int i = 0; i < 4; i++) begin
            sg[i] = 9'h0A0 + 9'(i);
            cfg[i] = '{IN_LUMA, 2'(i)};
            lvl[i] = 9'h000;
        end
        tick(6);
        nrst <= 1'b1;
        t_clamp();
        t_freeze();
        t_agc();
        t_tune();
        stop_test();
    end
endmodule
`default_nettype wire
